/* File: pdtx_ctrl.sv */
// transmit abort / retry / wait-for-idle control of a pd mac
// assumes a byte register port, a classified receive event, a coder stream
`timescale 1ns/10ps
module pdtx_ctrl
  import pdtx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [15:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       go,
  input  wire logic       abort_req,
  input  wire logic       ack_req,
  input  wire logic       ack_for_soft_reset,
  input  pdtx_sop_t       tx_sop,
  input  wire logic [5:0] pkt_len,
  input  wire logic       line_busy_pin,
  input  pdtx_rx_t        rx_event,
  input  wire logic       hard_reset_rx,
  input  wire logic       cable_reset_rx,
  input  wire logic       cable_reset_en,
  input  wire logic       goodcrc_rx,
  input  wire logic       ack_timeout,
  input  wire logic       q_valid,
  output logic            q_ready,
  input  pdtx_qword_t     q_word,
  output logic            line_valid,
  input  wire logic       line_ready,
  output pdtx_line_t      line_word,
  output logic            line_drive_en,
  output logic            send_done_flag,
  output logic            send_failed_flag,
  output logic            send_aborted_flag,
  output logic            queue_fifo_mode,
  output logic            raw_processing_on,
  output logic            auto_response_on
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] tx_control_a;
  logic [2:0] retry_limit, tries;
  logic [5:0] sent_cnt;
  logic       tx_active, is_ack, is_sr_ack;
  pdtx_sop_t  cur_sop;

  wire retry_busy   = tx_control_a[PDTX_RETRY_BUSY_BIT];
  wire keep_nonprim = tx_control_a[PDTX_KEEP_BIT];
  wire plain_sr_ack = tx_control_a[PDTX_PLAIN_BIT];
  wire hold_quiet   = tx_control_a[PDTX_HOLD_BIT];
  wire auto_rsp     = tx_control_a[PDTX_AUTO_BIT];

  wire sel_ctrl  = (reg_addr == PDTX_CTRL_A_ADDR);
  wire sel_stat  = (reg_addr == PDTX_STATUS_ADDR);
  wire sel_param = (reg_addr == PDTX_PARAM_C_ADDR);

  // bit 7 is read-only zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_control_a <= PDTX_CTRL_A_RESET;
    end else if (reg_wr && sel_ctrl) begin
      tx_control_a <= reg_wdata & PDTX_CTRL_A_WMASK;
    end
  end

  // three-bit retry count, zero means none
  always_ff @(posedge clock) begin
    if (!resetn) begin
      retry_limit <= PDTX_RETRY_RESET;
    end else if (reg_wr && sel_param) begin
      retry_limit <= reg_wdata[PDTX_RETRY_MSB:PDTX_RETRY_LSB];
    end
  end

  // status: tries in 6:4, active in bit 0; params: limit in 6:4
  wire [7:0] stat_byte  = {1'b0, tries, 3'h0, tx_active};
  wire [7:0] param_byte = {1'b0, retry_limit, 4'h0};
  wire [7:0] rd_mux     = sel_ctrl ? tx_control_a : sel_stat ? stat_byte
                          : sel_param ? param_byte : PDTX_ZERO_BYTE;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= PDTX_ZERO_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // mode outputs
  always_ff @(posedge clock) begin
    if (!resetn) begin
      queue_fifo_mode   <= 1'b0;
      raw_processing_on <= 1'b0;
      auto_response_on  <= 1'b0;
    end else begin
      queue_fifo_mode   <= tx_control_a[PDTX_FIFO_BIT];
      raw_processing_on <= tx_control_a[PDTX_RAW_BIT];
      auto_response_on  <= auto_rsp;
    end
  end

  // ****************************************
  // busy line synchroniser
  // ****************************************
  logic busy_m1, busy_m2, busy_m3, line_busy;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      busy_m1   <= 1'b0;
      busy_m2   <= 1'b0;
      busy_m3   <= 1'b0;
      line_busy <= 1'b0;
    end else begin
      busy_m1 <= line_busy_pin;
      busy_m2 <= busy_m1;
      busy_m3 <= busy_m2;
      if (busy_m2 == busy_m3) begin
        line_busy <= busy_m3;
      end
    end
  end

  // ****************************************
  // abort and attempt decisions
  // ****************************************
  typedef enum logic [2:0] {
    PDTX_ST_IDLE, PDTX_ST_TRY, PDTX_ST_HOLD, PDTX_ST_SEND, PDTX_ST_WAIT_ACK
  } pdtx_state_t;
  pdtx_state_t state, next_state;

  wire pending  = (state != PDTX_ST_IDLE);
  wire cur_prim = (cur_sop == PDTX_SOP);
  // no hardware retries without auto response
  wire [2:0] eff_limit = auto_rsp ? retry_limit : 3'h0;
  wire       can_retry = (tries < eff_limit);

  wire rx_counts = rx_event.valid && rx_event.good && !rx_event.dup
                   && !rx_event.ping && !rx_event.goodcrc;
  wire rx_same   = (rx_event.sop == cur_sop);
  // primary rx aborts non-primary unless kept
  wire rx_prim   = (rx_event.sop == PDTX_SOP) && !cur_prim && !keep_nonprim;
  wire rx_abort  = rx_counts && (rx_same || rx_prim);
  wire cab_abort = cable_reset_rx && cable_reset_en && !cur_prim;
  wire any_abort = pending && (hard_reset_rx || cab_abort || rx_abort
                   || abort_req);

  // soft reset ack keeps its special busy exemption
  wire sr_special = is_sr_ack && auto_rsp && !plain_sr_ack;

  wire       start    = !pending && (go || (ack_req && auto_rsp));
  wire       q_take   = q_valid && q_ready;
  wire       raw_end  = raw_processing_on && q_word.is_code
                        && (q_word.data == PDTX_CODE_END);
  wire       auto_end = !raw_processing_on
                        && ((sent_cnt + PDTX_ONE6) == pkt_len);
  wire       last_w   = raw_end || auto_end;
  wire       buf_ready;
  wire       to_buf   = q_take && !(q_word.is_code && !raw_end);

  logic fail_now, done_now, bump;
  always_comb begin
    next_state = state;
    fail_now   = 1'b0;
    done_now   = 1'b0;
    bump       = 1'b0;
    unique case (state)
      PDTX_ST_IDLE: begin
        if (start) begin
          next_state = PDTX_ST_TRY;
        end
      end
      PDTX_ST_TRY: begin
        if (!line_busy || sr_special) begin
          next_state = PDTX_ST_SEND;
        end else if (hold_quiet) begin
          next_state = PDTX_ST_HOLD;
        end else if (retry_busy && can_retry) begin
          bump = 1'b1;
        end else if (retry_busy && eff_limit != 3'h0) begin
          fail_now   = 1'b1;
          next_state = PDTX_ST_IDLE;
        end else begin
          next_state = PDTX_ST_IDLE;
        end
      end
      PDTX_ST_HOLD: begin
        if (!line_busy) begin
          next_state = PDTX_ST_SEND;
        end
      end
      PDTX_ST_SEND: begin
        if (q_take && last_w) begin
          if (is_ack) begin
            done_now   = 1'b1;
            next_state = PDTX_ST_IDLE;
          end else begin
            next_state = PDTX_ST_WAIT_ACK;
          end
        end
      end
      PDTX_ST_WAIT_ACK: begin
        if (goodcrc_rx) begin
          done_now   = 1'b1;
          next_state = PDTX_ST_IDLE;
        end else if (ack_timeout && can_retry) begin
          bump       = 1'b1;
          next_state = PDTX_ST_TRY;
        end else if (ack_timeout) begin
          fail_now   = 1'b1;
          next_state = PDTX_ST_IDLE;
        end
      end
    endcase
    if (any_abort) begin
      next_state = PDTX_ST_IDLE;
      fail_now   = 1'b0;
      done_now   = 1'b0;
    end
  end
  wire rule1_drop = (state == PDTX_ST_TRY) && line_busy && !sr_special
                    && !hold_quiet && !(retry_busy && eff_limit != 3'h0);

  // ****************************************
  // state and status
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= PDTX_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tries     <= 3'h0;
      is_ack    <= 1'b0;
      is_sr_ack <= 1'b0;
      cur_sop   <= PDTX_SOP;
    end else if (start) begin
      tries     <= 3'h0;
      is_ack    <= !go;
      is_sr_ack <= !go && ack_for_soft_reset;
      cur_sop   <= tx_sop;
    end else if (bump && !any_abort) begin
      tries <= tries + PDTX_ONE3;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || state != PDTX_ST_SEND) begin
      sent_cnt <= 6'h00;
    end else if (q_take) begin
      sent_cnt <= sent_cnt + PDTX_ONE6;
    end
  end

  // flags stay until the next start
  always_ff @(posedge clock) begin
    if (!resetn || start) begin
      send_done_flag    <= 1'b0;
      send_failed_flag  <= 1'b0;
      send_aborted_flag <= 1'b0;
    end else begin
      send_done_flag    <= send_done_flag | done_now;
      send_failed_flag  <= send_failed_flag | fail_now;
      send_aborted_flag <= send_aborted_flag | any_abort | rule1_drop;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_active     <= 1'b0;
      line_drive_en <= 1'b0;
      q_ready       <= 1'b0;
    end else begin
      tx_active     <= (next_state != PDTX_ST_IDLE);
      line_drive_en <= (next_state == PDTX_ST_SEND);
      q_ready       <= (next_state == PDTX_ST_SEND) && buf_ready && !q_take;
    end
  end

  // ****************************************
  // line buffer
  // ****************************************
  wire pdtx_line_t buf_in = '{last_w, q_word.data};

  pdtx_buf2 u_buf (
    .clock     (clock),
    .resetn    (resetn),
    .flush     (any_abort),
    .in_valid  (to_buf),
    .in_ready  (buf_ready),
    .in_word   (buf_in),
    .out_valid (line_valid),
    .out_ready (line_ready),
    .out_word  (line_word)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  ctrl_bit7_a: assert property (tx_control_a[7] == 1'b0)
    else $error("reserved control bit set");
  busy_drop_a: assert property (rule1_drop |=> state == PDTX_ST_IDLE
    && send_aborted_flag && !send_failed_flag)
    else $error("busy line did not drop packet");
  busy_retry_a: assert property ((state == PDTX_ST_TRY) && line_busy && !hold_quiet
    && !sr_special && retry_busy && can_retry && !any_abort
    |=> tries == $past(tries) + PDTX_ONE3)
    else $error("busy retry not counted");
  retry_fail_a: assert property (fail_now |=> send_failed_flag && !send_aborted_flag)
    else $error("failure not reported");
  reset_abort_a: assert property (pending && hard_reset_rx |=> state == PDTX_ST_IDLE
    && send_aborted_flag)
    else $error("hard reset did not abort");
  rx_abort_a: assert property (pending && rx_abort |=> !tx_active && !line_drive_en)
    else $error("matching packet did not abort");
  sw_abort_a: assert property (pending && abort_req |=> state == PDTX_ST_IDLE)
    else $error("software abort ignored");
  keep_type_a: assert property (keep_nonprim && !cur_prim && rx_abort
    |-> rx_event.sop == cur_sop)
    else $error("other type aborted kept packet");
  sr_ack_a: assert property ((state == PDTX_ST_TRY) && sr_special && !any_abort
    |=> state == PDTX_ST_SEND)
    else $error("soft reset ack held by busy line");
  hold_quiet_a: assert property ((state == PDTX_ST_TRY) && line_busy && hold_quiet
    && !sr_special && !any_abort |=> state == PDTX_ST_HOLD
    ##0 !send_aborted_flag)
    else $error("hold option did not wait");
  no_auto_a: assert property (!auto_rsp && !go && ack_req && !pending
    |=> state == PDTX_ST_IDLE)
    else $error("ack sent with auto response off");
  no_retry_a: assert property ((state == PDTX_ST_TRY) && line_busy && !auto_rsp
    && !hold_quiet |=> state == PDTX_ST_IDLE)
    else $error("retry with auto response off");

  send_c: cover property (state == PDTX_ST_WAIT_ACK ##[1:40] send_done_flag);
  fail_c: cover property (fail_now);
  hold_c: cover property (state == PDTX_ST_HOLD ##1 state == PDTX_ST_SEND);
  stall_c: cover property (line_valid && !line_ready [*3]);

endmodule

/* File: pdtx_pkg.sv */
// constants, types and register map of the transmit abort/retry control
// assumes one 100 MHz clock and a byte-wide register port
package pdtx_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] PDTX_CTRL_A_ADDR  = 16'h1a00;
  localparam logic [15:0] PDTX_STATUS_ADDR  = 16'h1a01;
  localparam logic [15:0] PDTX_PARAM_C_ADDR = 16'h1a02;
  localparam logic [7:0]  PDTX_CTRL_A_RESET = 8'h00;
  localparam logic [7:0]  PDTX_CTRL_A_WMASK = 8'h7f;
  localparam logic [2:0]  PDTX_RETRY_RESET  = 3'h0;
  localparam logic [7:0]  PDTX_ZERO_BYTE    = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PDTX_RETRY_BUSY_BIT = 6;
  localparam int PDTX_KEEP_BIT       = 5;
  localparam int PDTX_PLAIN_BIT      = 4;
  localparam int PDTX_HOLD_BIT       = 3;
  localparam int PDTX_AUTO_BIT       = 2;
  localparam int PDTX_FIFO_BIT       = 1;
  localparam int PDTX_RAW_BIT        = 0;
  localparam int PDTX_RETRY_LSB      = 4;
  localparam int PDTX_RETRY_MSB      = 6;
  localparam int PDTX_ACTIVE_BIT     = 0;

  // raw mode code that ends a packet after the crc
  localparam logic [7:0] PDTX_CODE_END = 8'h01;
  localparam logic [2:0] PDTX_ONE3     = 3'h1;
  localparam logic [5:0] PDTX_ONE6     = 6'h01;

  typedef enum logic [2:0] {
    PDTX_SOP, PDTX_SOP_P, PDTX_SOP_PP, PDTX_SOP_P_DBG, PDTX_SOP_PP_DBG
  } pdtx_sop_t;

  // queue word: data byte or raw mode code
  typedef struct packed {
    logic       is_code;
    logic [7:0] data;
  } pdtx_qword_t;

  // word toward the line coder
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } pdtx_line_t;

  // one received packet as classified by the receive path
  typedef struct packed {
    logic      valid;
    logic      good;
    logic      dup;
    logic      ping;
    logic      goodcrc;
    pdtx_sop_t sop;
  } pdtx_rx_t;

endpackage

/* File: pdtx_buf2.sv */
// two-entry buffer between transmit control and the line coder
// assumes the coder may stall; flush empties it at once
`timescale 1ns/10ps
module pdtx_buf2
  import pdtx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       flush,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  pdtx_line_t      in_word,
  output logic            out_valid,
  input  wire logic       out_ready,
  output pdtx_line_t      out_word
);

  pdtx_line_t mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_word  = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_word;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

/* File: pdtx_line_sink.sv */
// line coder stand-in: takes words from the transmit buffer and logs them
// assumes the bench picks prompt, slow or stalled acceptance
`timescale 1ns/10ps
module pdtx_line_sink
  import pdtx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       clr,
  input  wire logic [1:0] mode,
  input  wire logic       line_valid,
  input  pdtx_line_t      line_word,
  output logic            line_ready,
  output logic [3:0]      count
);
  // ****************************************
  // acceptance and word log
  // ****************************************
  logic       tick;
  pdtx_line_t seen [16];
  wire        take = line_valid && line_ready;

  // 0 prompt, 1 every other cycle, 2 stalled
  assign line_ready = (mode == 2'h0) || ((mode == 2'h1) && tick);

  always_ff @(posedge clock) begin
    if (!resetn || clr) begin
      tick  <= 1'b0;
      count <= 4'h0;
    end else begin
      tick <= ~tick;
      if (take) begin
        seen[count] <= line_word;
        count       <= count + 4'h1;
      end
    end
  end
endmodule

/* File: tb.sv */
// bench for the transmit abort/retry control
// assumes the line coder stand-in on the line stream, queue driven here
`timescale 1ns/10ps
module tb
  import pdtx_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       ack;
    logic       busy;
    pdtx_sop_t  sop;
    logic [2:0] ev;
    pdtx_sop_t  rsop;
    logic [3:0] exp;
  } pdtx_row_t;

  localparam pdtx_sop_t S0 = PDTX_SOP;
  localparam pdtx_sop_t S1 = PDTX_SOP_P;
  localparam pdtx_sop_t S2 = PDTX_SOP_PP;

  logic        clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic        abort_req = 1'b0, ack_req = 1'b0, ack_for_soft_reset = 1'b0;
  logic        line_busy_pin = 1'b0, hard_reset_rx = 1'b0, cable_reset_rx = 1'b0;
  logic        cable_reset_en = 1'b1, goodcrc_rx = 1'b0, ack_timeout = 1'b0;
  logic        q_valid = 1'b0, clr = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd;
  logic [5:0]  pkt_len = 6'h03;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  count;
  pdtx_sop_t   tx_sop = PDTX_SOP;
  pdtx_rx_t    rx_event = '0;
  pdtx_qword_t q_word = '0;
  pdtx_line_t  line_word;
  logic        q_ready, line_valid, line_ready, line_drive_en, send_done_flag;
  logic        send_failed_flag, send_aborted_flag, queue_fifo_mode, raw_processing_on;
  logic        auto_response_on;
  int          err_total = 0, n_checks = 0;
  pdtx_row_t   rows [19];
  pdtx_row_t   r;
  pdtx_qword_t words [4];

  always #5 clock = ~clock;

  pdtx_ctrl i_pdtx_ctrl (.clock, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .go, .abort_req, .ack_req, .ack_for_soft_reset, .tx_sop, .pkt_len,
    .line_busy_pin, .rx_event, .hard_reset_rx, .cable_reset_rx, .cable_reset_en,
    .goodcrc_rx, .ack_timeout, .q_valid, .q_ready, .q_word, .line_valid, .line_ready,
    .line_word, .line_drive_en, .send_done_flag, .send_failed_flag, .send_aborted_flag,
    .queue_fifo_mode, .raw_processing_on, .auto_response_on);

  pdtx_line_sink i_pdtx_line_sink (.clock, .resetn, .clr, .mode, .line_valid,
    .line_word, .line_ready, .count);

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [15:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // settle after n edges, then sample
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // words handed over one at a time, each held until taken or until 60 cycles pass
  task automatic send(input int n);
    int k;
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      q_valid <= 1'b1;
      q_word  <= words[i];
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (!q_ready && k < 60);
    end
    q_valid <= 1'b0;
  endtask

  task automatic start(input logic a);
    @(posedge clock);
    go                 <= !a;
    ack_req            <= a;
    ack_for_soft_reset <= a;
    clr                <= 1'b1;
    @(posedge clock);
    go                 <= 1'b0;
    ack_req            <= 1'b0;
    ack_for_soft_reset <= 1'b0;
    clr                <= 1'b0;
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    complete_run;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    // ctrl, ack, busy, sop, ev (1 hard 2 cable 3 rx 4 ping), rx sop, {done,fail,abort,drive}
    // ev 5: cable reset while cable reset is disabled
    rows = '{'{8'h00, 1'b1, 1'b0, S0, 3'h0, S0, 4'h0},
             '{8'h00, 1'b0, 1'b1, S0, 3'h0, S0, 4'h2},
             '{8'h44, 1'b0, 1'b1, S0, 3'h0, S0, 4'h4},
             '{8'h40, 1'b0, 1'b1, S0, 3'h0, S0, 4'h2},
             '{8'h48, 1'b0, 1'b1, S0, 3'h0, S0, 4'h0},
             '{8'h4c, 1'b0, 1'b1, S0, 3'h0, S0, 4'h0},
             '{8'h04, 1'b1, 1'b1, S0, 3'h0, S0, 4'h1},
             '{8'h14, 1'b1, 1'b1, S0, 3'h0, S0, 4'h2},
             '{8'h1c, 1'b1, 1'b1, S0, 3'h0, S0, 4'h0},
             '{8'h00, 1'b0, 1'b0, S0, 3'h1, S0, 4'h2},
             '{8'h00, 1'b0, 1'b0, S1, 3'h2, S0, 4'h2},
             '{8'h00, 1'b0, 1'b0, S0, 3'h2, S0, 4'h1},
             '{8'h00, 1'b0, 1'b0, S1, 3'h3, S1, 4'h2},
             '{8'h00, 1'b0, 1'b0, S1, 3'h3, S0, 4'h2},
             '{8'h20, 1'b0, 1'b0, S1, 3'h3, S0, 4'h1},
             '{8'h20, 1'b0, 1'b0, S1, 3'h3, S1, 4'h2},
             '{8'h00, 1'b0, 1'b0, S0, 3'h4, S0, 4'h1},
             '{8'h00, 1'b0, 1'b0, S0, 3'h3, S2, 4'h1},
             '{8'h00, 1'b0, 1'b0, S1, 3'h5, S0, 4'h1}};
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rdr(PDTX_CTRL_A_ADDR);
    chk(rd, 16'h0000);
    wr(PDTX_CTRL_A_ADDR, 8'hff);
    rdr(PDTX_CTRL_A_ADDR);
    chk(rd, 16'h007f);
    chk({auto_response_on, queue_fifo_mode, raw_processing_on}, 16'h0007);
    rdr(16'h1a10);
    chk(rd, 16'h0000);
    wr(PDTX_CTRL_A_ADDR, 8'h00);
    wr(PDTX_PARAM_C_ADDR, 8'h20);
    rdr(PDTX_PARAM_C_ADDR);
    chk(rd, 16'h0020);
    foreach (rows[i]) begin
      r = rows[i];
      wr(PDTX_CTRL_A_ADDR, r.ctrl);
      @(posedge clock);
      line_busy_pin <= r.busy;
      tx_sop        <= r.sop;
      repeat (4) @(posedge clock);
      start(r.ack);
      repeat (8) @(posedge clock);
      hard_reset_rx  <= (r.ev == 3'h1);
      cable_reset_rx <= (r.ev == 3'h2) || (r.ev == 3'h5);
      cable_reset_en <= (r.ev != 3'h5);
      rx_event       <= '{(r.ev == 3'h3) || (r.ev == 3'h4), 1'b1, 1'b0, r.ev == 3'h4, 1'b0,
                          r.rsop};
      @(posedge clock);
      hard_reset_rx  <= 1'b0;
      cable_reset_rx <= 1'b0;
      cable_reset_en <= 1'b1;
      rx_event       <= '0;
      wt(4);
      chk({send_done_flag, send_failed_flag, send_aborted_flag, line_drive_en}, r.exp);
      @(posedge clock);
      abort_req <= 1'b1;
      @(posedge clock);
      abort_req     <= 1'b0;
      line_busy_pin <= 1'b0;
      wt(3);
      chk({send_aborted_flag, line_drive_en}, {i > 0 && r.exp != 4'h4, 1'b0});
    end
    // held by a busy line, then sent once quiet, with the coder stalling
    wr(PDTX_CTRL_A_ADDR, 8'h08);
    @(posedge clock);
    line_busy_pin <= 1'b1;
    tx_sop        <= S0;
    mode          <= 2'h2;
    repeat (4) @(posedge clock);
    start(1'b0);
    wt(6);
    chk(line_drive_en, 16'h0000);
    rdr(PDTX_STATUS_ADDR);
    chk(rd, 16'h0001);
    @(posedge clock);
    line_busy_pin <= 1'b0;
    words = '{'{1'b0, 8'h11}, '{1'b0, 8'h22}, '{1'b0, 8'h33}, '{1'b0, 8'h44}};
    fork
      send(3);
      begin
        repeat (14) @(posedge clock);
        mode <= 2'h1;
      end
    join
    wt(20);
    chk(count, 16'h0003);
    chk(i_pdtx_line_sink.seen[0], 16'h0011);
    chk(i_pdtx_line_sink.seen[2], 16'h0133);
    @(posedge clock);
    goodcrc_rx <= 1'b1;
    @(posedge clock);
    goodcrc_rx <= 1'b0;
    mode       <= 2'h0;
    wt(3);
    chk(send_done_flag, 16'h0001);
    // raw mode: other codes dropped, end code closes the packet
    wr(PDTX_CTRL_A_ADDR, 8'h01);
    start(1'b0);
    words = '{'{1'b0, 8'ha5}, '{1'b1, 8'h07}, '{1'b0, 8'h5a}, '{1'b1, 8'h01}};
    send(4);
    wt(10);
    chk(count, 16'h0003);
    chk(i_pdtx_line_sink.seen[1], 16'h005a);
    chk(i_pdtx_line_sink.seen[2], 16'h0101);
    // ack wait expires with auto response off: no retry, failed
    @(posedge clock);
    ack_timeout <= 1'b1;
    @(posedge clock);
    ack_timeout <= 1'b0;
    wt(3);
    chk({send_failed_flag, send_aborted_flag}, 16'h0002);
    // reset in mid-run clears control and flags
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rdr(PDTX_CTRL_A_ADDR);
    chk({rd, send_failed_flag, raw_processing_on}, 16'h0000);
    complete_run;
  end
endmodule
